// >>> rtl/ats_adc_ctrl.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module ats_adc_ctrl (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ats_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [ats_pkg::DATA_W-1:0] pwdata_i,
  output logic [ats_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Trigger event sources
  input wire logic [ats_pkg::NUM_SEQ-1:0] proc_start_i,
  input wire logic comparator0_i,
  input wire logic external_trigger_pin_i,
  input wire logic timer_i,
  input wire logic pwm_gen0_trigger_i,
  input wire logic pwm_gen1_trigger_i,
  input wire logic pwm_gen2_trigger_i,
  // Conversion results, one write per sequencer
  input wire logic [ats_pkg::NUM_SEQ-1:0] sample_wr_i,
  input wire logic [ats_pkg::SAMPLE_W-1:0] sample_data_i,
  // Sequencer starts and interrupt
  output logic [ats_pkg::NUM_SEQ-1:0] seq_start_o,
  output logic irq_o
);
  localparam int N = ats_pkg::NUM_SEQ;

  typedef struct packed {
    logic [N-1:0][ats_pkg::SEL_W-1:0] trig_sel;
    logic [N-1:0] underflow;
    logic [N-1:0] int_en;
    logic [ats_pkg::DATA_W-1:0] rdata;
    logic ready;
    logic err;
    logic irq;
    logic [N-1:0][ats_pkg::PTR_W-1:0] rd_ptr;
    logic [N-1:0][ats_pkg::PTR_W-1:0] wr_ptr;
    logic [N-1:0][ats_pkg::CNT_W-1:0] count;
  } ats_ctrl_state_t;

  ats_ctrl_state_t st_r;
  ats_ctrl_state_t st_nxt;
  logic [ats_pkg::SAMPLE_W-1:0] fifo_mem [N][ats_pkg::FIFO_DEPTH];
  logic [N-1:0][ats_pkg::SEL_W-1:0] sel_w;
  logic [N-1:0] start_w;

  // Index of the result FIFO addressed, or N when none
  function automatic logic [2:0] fifo_index(input logic [ats_pkg::ADDR_W-1:0] a);
    logic [2:0] idx;
    idx = 3'(N);
    for (int k = 0; k < N; k++) begin
      if (a == ats_pkg::ADDR_W'(ats_pkg::OFF_FIFO0 + k * ats_pkg::OFF_FIFO_STRIDE)) begin
        idx = 3'(k);
      end
    end
    return idx;
  endfunction : fifo_index

  // Each sequencer has its own mux instance
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_seq
      ats_seq_if sif ();
      assign sif.sel = sel_w[g];
      assign start_w[g] = sif.start;
      ats_trig_mux u_mux (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .proc_start_i(proc_start_i[g]),
        .comparator0_i(comparator0_i),
        .external_trigger_pin_i(external_trigger_pin_i),
        .timer_i(timer_i),
        .pwm_gen0_trigger_i(pwm_gen0_trigger_i),
        .pwm_gen1_trigger_i(pwm_gen1_trigger_i),
        .pwm_gen2_trigger_i(pwm_gen2_trigger_i),
        .seq(sif.mux)
      );
    end
  endgenerate

  assign sel_w = st_r.trig_sel;

  logic access_w;
  logic commit_w;
  logic wr_w;
  logic rd_w;
  logic [2:0] fidx_w;
  assign access_w = psel_i && penable_i && !st_r.ready;
  // Writes land at the edge that completes the transfer, where the master samples pready
  assign commit_w = psel_i && penable_i && st_r.ready;
  assign wr_w = commit_w && pwrite_i;
  assign rd_w = access_w && !pwrite_i;
  assign fidx_w = fifo_index(paddr_i);

  always_comb begin
    logic pop;
    logic push;
    pop = 1'b0;
    push = 1'b0;
    st_nxt = st_r;
    st_nxt.ready = access_w;
    st_nxt.err = 1'b0;
    st_nxt.rdata = '0;
    for (int k = 0; k < N; k++) begin
      pop = rd_w && (fidx_w == 3'(k)) && (st_r.count[k] != '0);
      push = sample_wr_i[k] && (st_r.count[k] != ats_pkg::CNT_W'(ats_pkg::FIFO_DEPTH));
      // Empty read keeps pointers still
      if (pop) begin
        st_nxt.rd_ptr[k] = st_r.rd_ptr[k] + 1'b1;
      end
      if (push) begin
        st_nxt.wr_ptr[k] = st_r.wr_ptr[k] + 1'b1;
      end
      st_nxt.count[k] = st_r.count[k] + {3'b000, push} - {3'b000, pop};
      // Write one clears; a same-cycle underflow wins
      if (wr_w && paddr_i == ats_pkg::OFF_UNDERFLOW && pwdata_i[k]) begin
        st_nxt.underflow[k] = 1'b0;
      end
      if (wr_w && paddr_i == ats_pkg::OFF_INT_CLR && pwdata_i[k]) begin
        st_nxt.underflow[k] = 1'b0;
      end
      if (rd_w && fidx_w == 3'(k) && st_r.count[k] == '0) begin
        st_nxt.underflow[k] = 1'b1;
      end
    end
    if (wr_w && paddr_i == ats_pkg::OFF_TRIG_SEL) begin
      st_nxt.trig_sel = pwdata_i[15:0];
    end
    if (wr_w && paddr_i == ats_pkg::OFF_INT_EN) begin
      st_nxt.int_en = pwdata_i[N-1:0];
    end
    if (access_w && pwrite_i) begin
      // The error must ride with pready, so it is decoded at the taking edge
      unique case (paddr_i)
        ats_pkg::OFF_TRIG_SEL, ats_pkg::OFF_INT_EN: st_nxt.err = 1'b0;
        ats_pkg::OFF_UNDERFLOW, ats_pkg::OFF_INT_CLR: st_nxt.err = 1'b0;
        default: st_nxt.err = 1'b1;
      endcase
    end else if (rd_w) begin
      // Upper bits read as zero
      unique case (paddr_i)
        ats_pkg::OFF_TRIG_SEL: st_nxt.rdata = {16'h0000, st_r.trig_sel};
        ats_pkg::OFF_UNDERFLOW: st_nxt.rdata = {28'h000_0000, st_r.underflow};
        ats_pkg::OFF_INT_EN: st_nxt.rdata = {28'h000_0000, st_r.int_en};
        default: begin
          if (fidx_w == 3'(N)) begin
            st_nxt.err = 1'b1;
          end else if (st_r.count[fidx_w[1:0]] != '0) begin
            st_nxt.rdata = {22'h00_0000,
                            fifo_mem[fidx_w[1:0]][st_r.rd_ptr[fidx_w[1:0]]]};
          end else begin
            st_nxt.rdata = '0;
          end
        end
      endcase
    end
    st_nxt.irq = |(st_nxt.underflow & st_nxt.int_en);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.trig_sel <= ats_pkg::TRIG_SEL_RESET;
      st_r.underflow <= ats_pkg::UNDERFLOW_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Result storage; contents need no reset
  always_ff @(posedge clock_i) begin
    for (int k = 0; k < N; k++) begin
      if (sample_wr_i[k] && st_r.count[k] != ats_pkg::CNT_W'(ats_pkg::FIFO_DEPTH)) begin
        fifo_mem[k][st_r.wr_ptr[k]] <= sample_data_i;
      end
    end
  end

  assign prdata_o = st_r.rdata;
  assign pready_o = st_r.ready;
  assign pslverr_o = st_r.err;
  assign seq_start_o = start_w;
  assign irq_o = st_r.irq;
endmodule : ats_adc_ctrl

// >>> rtl/ats_pkg.sv
// How it works
// - Each of four sequencers has its own independently programmed trigger source.
// - Sequencer 3 trigger select is read/write bits 15:12, reset zero.
// - Sequencers 2,1,0 selects sit at 11:8, 7:4, 3:0, reset zero.
// - Codes: 0 processor, 1 comparator, 4 pin, 5 timer, 6-8 PWM, F continuous.
// - The selected event starts a sampling run of its sequencer.
// - Reserved upper bits of both registers read zero and ignore writes.
// - Reading an empty result FIFO sets that sequencer's underflow flag.
// - Empty FIFO read leaves pointers alone and returns zero data.
// - Underflow flags reset zero, clear only by writing one to the flag register or the interrupt-clear register.
package ats_pkg;
  localparam int NUM_SEQ = 4;
  localparam int SEL_W = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int SAMPLE_W = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_TRIG_SEL = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_UNDERFLOW = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_INT_EN = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_INT_CLR = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_FIFO0 = 12'h048;
  localparam logic [ADDR_W-1:0] OFF_FIFO_STRIDE = 12'h020;

  localparam logic [15:0] TRIG_SEL_RESET = 16'h0000;
  localparam logic [3:0] UNDERFLOW_RESET = 4'h0;

  // Trigger source codes
  localparam logic [SEL_W-1:0] TRG_PROCESSOR = 4'h0;
  localparam logic [SEL_W-1:0] TRG_COMPARATOR0 = 4'h1;
  localparam logic [SEL_W-1:0] TRG_EXT_PIN = 4'h4;
  localparam logic [SEL_W-1:0] TRG_TIMER = 4'h5;
  localparam logic [SEL_W-1:0] TRG_PWM_GEN0_TRIGGER = 4'h6;
  localparam logic [SEL_W-1:0] TRG_PWM_GEN1_TRIGGER = 4'h7;
  localparam logic [SEL_W-1:0] TRG_PWM_GEN2_TRIGGER = 4'h8;
  localparam logic [SEL_W-1:0] TRG_ALWAYS = 4'hF;
endpackage : ats_pkg

// >>> rtl/ats_seq_if.sv
`timescale 1ns/1ps
// One sequencer's trigger select and fired start strobe
interface ats_seq_if;
  logic [ats_pkg::SEL_W-1:0] sel;
  logic start;
  modport ctl (output sel, input start);
  modport mux (input sel, output start);
endinterface : ats_seq_if

// >>> rtl/ats_trig_mux.sv
`timescale 1ns/1ps
module ats_trig_mux (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Event sources, one-cycle pulses except continuous
  input wire logic proc_start_i,
  input wire logic comparator0_i,
  input wire logic external_trigger_pin_i,
  input wire logic timer_i,
  input wire logic pwm_gen0_trigger_i,
  input wire logic pwm_gen1_trigger_i,
  input wire logic pwm_gen2_trigger_i,
  // Sequencer select and start
  ats_seq_if.mux seq
);
  typedef struct packed {
    logic start;
  } ats_mux_state_t;
  ats_mux_state_t st_r;
  ats_mux_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    unique case (seq.sel)
      ats_pkg::TRG_PROCESSOR: st_nxt.start = proc_start_i;
      ats_pkg::TRG_COMPARATOR0: st_nxt.start = comparator0_i;
      ats_pkg::TRG_EXT_PIN: st_nxt.start = external_trigger_pin_i;
      ats_pkg::TRG_TIMER: st_nxt.start = timer_i;
      ats_pkg::TRG_PWM_GEN0_TRIGGER: st_nxt.start = pwm_gen0_trigger_i;
      ats_pkg::TRG_PWM_GEN1_TRIGGER: st_nxt.start = pwm_gen1_trigger_i;
      ats_pkg::TRG_PWM_GEN2_TRIGGER: st_nxt.start = pwm_gen2_trigger_i;
      ats_pkg::TRG_ALWAYS: st_nxt.start = 1'b1;
      // Reserved codes never start a run
      default: st_nxt.start = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign seq.start = st_r.start;
endmodule : ats_trig_mux

// >>> tb/ats_adc_ctrl_checker.sv
`timescale 1ns/1ps
module ats_adc_ctrl_checker (
  // Clock, reset and bus
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ats_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [ats_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [ats_pkg::DATA_W-1:0] prdata_o,
  input wire logic pready_o,
  // Events and starts
  input wire logic [ats_pkg::NUM_SEQ-1:0] proc_start_i,
  input wire logic timer_i,
  input wire logic [ats_pkg::NUM_SEQ-1:0] seq_start_o
);
  logic [15:0] sel_r;
  logic [15:0] sel_nxt;
  wire logic taken = psel_i && penable_i && !pready_o;
  wire logic done = psel_i && penable_i && pready_o;
  wire logic rd_ans = pready_o && !pwrite_i;
  // Shadow select, updated at the edge that completes a write
  always_comb begin
    sel_nxt = sel_r;
    if (done && pwrite_i && paddr_i == ats_pkg::OFF_TRIG_SEL) sel_nxt = pwdata_i[15:0];
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) sel_r <= 16'h0000;
    else sel_r <= sel_nxt;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_taken;
    taken;
  endsequence
  sequence s_answer;
    pready_o ##1 !pready_o;
  endsequence
  a_ready_one_pulse: assert property (s_taken |=> s_answer) else $error("bad ready");
  a_proc_start_seq0: assert property (
    sel_r[3:0] == 4'h0 |=> seq_start_o[0] == $past(proc_start_i[0]))
    else $error("seq0 start");
  a_timer_start_seq1: assert property (
    sel_r[7:4] == 4'h5 |=> seq_start_o[1] == $past(timer_i))
    else $error("seq1 start");
  a_always_seq3: assert property (
    sel_r[15:12] == 4'hF |=> seq_start_o[3])
    else $error("seq3 start");
  a_reserved_seq2: assert property (
    sel_r[11:8] inside {4'h2, 4'h3, [4'h9:4'hE]} |=> !seq_start_o[2])
    else $error("seq2 start");
  a_sel_readback: assert property (
    rd_ans && paddr_i == ats_pkg::OFF_TRIG_SEL |-> prdata_o == {16'h0000, sel_r})
    else $error("select read");
  a_flags_upper: assert property (
    rd_ans && paddr_i == ats_pkg::OFF_UNDERFLOW |-> prdata_o[31:4] == 28'h000_0000)
    else $error("flag read");
  a_idle_rdata: assert property (!pready_o |-> prdata_o == 32'h0000_0000) else $error("idle data");
endmodule : ats_adc_ctrl_checker
bind ats_adc_ctrl ats_adc_ctrl_checker u_checker (.*);

// >>> tb/ats_apb_master.sv
`timescale 1ns/1ps
module ats_apb_master (
  // Clock and answer
  input wire logic clock_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  // Request
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end
  // Leading edge keeps an idle cycle, so psel is never assigned twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clock_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clock_i);
    penable_o <= 1'b1;
    do @(posedge clock_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released data flips so a stale word never looks valid
    pwdata_o <= ~d;
  endtask : xfer
endmodule : ats_apb_master

// >>> tb/adc_trigger_select_underflow_tb_top.sv
`timescale 1ns/1ps
module adc_trigger_select_underflow_tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, err, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] seq_start;
  logic [3:0] sample_wr = 4'h0;
  logic [9:0] sample_data = 10'h000;
  // Order: pwm_gen2_trigger, pwm_gen1_trigger, pwm_gen0_trigger, timer, pin, comparator, processor
  logic [6:0] ev = 7'h00;
  logic [6:0] src_tab [16] = '{7'h01, 7'h02, 7'h00, 7'h00, 7'h04, 7'h08, 7'h10, 7'h20,
                               7'h40, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  ats_adc_ctrl DUT (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .proc_start_i({4{ev[0]}}), .comparator0_i(ev[1]),
    .external_trigger_pin_i(ev[2]), .timer_i(ev[3]), .pwm_gen0_trigger_i(ev[4]),
    .pwm_gen1_trigger_i(ev[5]), .pwm_gen2_trigger_i(ev[6]), .sample_wr_i(sample_wr),
    .sample_data_i(sample_data), .seq_start_o(seq_start), .irq_o(irq));
  ats_apb_master u_host (.clock_i(clock_i), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  task automatic complete_run;
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, err);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0000_0000, q, err);
    check(q, e);
  endtask : rd
  task automatic fire(input logic [6:0] m, input logic [3:0] e);
    @(posedge clock_i);
    ev <= m;
    @(posedge clock_i);
    ev <= 7'h00;
    #1;
    check({28'h0, seq_start}, {28'h0, e});
  endtask : fire
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(12'h014, 32'h0000_0000);
    rd(12'h018, 32'h0000_0000);
    for (int c = 0; c < 16; c++) begin
      wr(12'h014, {16'h0000, {4{c[3:0]}}});
      fire(~src_tab[c], (c == 15) ? 4'hF : 4'h0);
      fire(src_tab[c], (c == 15 || src_tab[c] != 0) ? 4'hF : 4'h0);
    end
    wr(12'h014, 32'hFFFF_F150);
    rd(12'h014, 32'h0000_F150);
    fire(7'h08, 4'hA);
    for (int k = 0; k < 4; k++) begin
      rd(12'h048 + 12'(32 * k), 32'h0000_0000);
      rd(12'h018, 32'((2 << k) - 1));
    end
    wr(12'h018, 32'h0000_0000);
    rd(12'h018, 32'h0000_000F);
    wr(12'h01C, 32'h0000_0002);
    #1;
    check({31'h0, irq}, 32'h1);
    rd(12'h01C, 32'h0000_0002);
    check({31'h0, err}, 32'h0);
    wr(12'h024, 32'h0000_0002);
    #1;
    check({31'h0, irq}, 32'h0);
    wr(12'h018, 32'h0000_0005);
    rd(12'h018, 32'h0000_0008);
    @(posedge clock_i);
    sample_wr <= 4'h2;
    sample_data <= 10'h2AB;
    @(posedge clock_i);
    sample_wr <= 4'h0;
    rd(12'h068, 32'h0000_02AB);
    rd(12'h068, 32'h0000_0000);
    rd(12'h018, 32'h0000_000A);
    u_host.xfer(1'b0, 12'h100, 32'h0000_0000, q, err);
    check({31'h0, err}, 32'h1);
    u_host.xfer(1'b1, 12'h100, 32'hFFFF_FFFF, q, err);
    check({31'h0, err}, 32'h1);
    complete_run();
  end
endmodule : adc_trigger_select_underflow_tb_top
